// *** design/aicb_exec.v ***
// execute stage for and-immediate and compare-branch instructions
`include "aicb_defs.vh"

module aicb_exec (
	input  wire        core_clk,
	input  wire        sys_rst,
	input  wire        instr_valid,
	input  wire [31:0] instr_word,
	input  wire [31:0] instr_pc,
	input  wire [31:0] first_source_val,
	input  wire [31:0] second_source_val,
	output reg  [4:0]  first_source_reg,
	output reg  [4:0]  second_reg_field,
	output reg         wr_en_q,
	output reg  [4:0]  wr_idx_q,
	output reg  [31:0] wr_data_q,
	output reg         pc_valid_q,
	output reg  [31:0] next_pc_q,
	output reg         branch_taken_q,
	output reg         misalign_exc_q,
	output reg         illegal_q
);
	// timing, as seen from the pipeline around this stage:
	//   edge n   : instruction word, pc and both operand values sampled
	//   edge n+1 : every output below is loaded from a flop
	// pulses (write enable, pc valid, taken, trap, illegal) last one cycle;
	// the data outputs follow the inputs on every edge, valid or not, so a
	// consumer must qualify them with the matching pulse.
	// operand values arrive as ports; the register file sits outside and is
	// addressed with the registered field copies one cycle late, which the
	// surrounding pipeline has to allow for.
	// the swapped-operand branch aliases need no decode here: the assembler
	// has already turned them into one of the four real compares.
	// an unknown opcode is not trapped here; it raises illegal_q and the pc
	// simply steps, leaving the decision to the exception logic upstream.
	// a taken branch to an unaligned target drops pc_valid_q and raises the
	// trap pulse, while next_pc_q still shows the target for the handler.
	// no state is kept between instructions, so back-to-back issue is fine
	//   and a reset in mid-stream clears the pulses and indices and zeroes wr_data_q and next_pc_q.
	// the unsigned less-than branch and other opcodes are decoded elsewhere.
	// all compares are combinational from the ports; the critical path is
	//   operand in, 32-bit compare, next-pc select, flop.
	// widths are fixed: 32-bit data, 5-bit indices, 6-bit opcode.
	// a 16-bit displacement reaches 32 kbytes either side of the next pc.

	wire [5:0]  opc;
	wire [15:0] sixteen_bit_immediate;
	wire [31:0] imm_sext;
	wire [31:0] seq_pc;
	wire [31:0] tgt_pc;
	wire        is_andhi;
	wire        is_andlo;
	wire        is_beq;
	wire        is_bge;
	wire        is_bgeu;
	wire        is_blt;
	wire        is_branch;
	reg         cond;
	wire [31:0] hi_mask;
	wire [31:0] lo_mask;
	wire [31:0] hi_res;
	wire [31:0] lo_res;
	wire        eq_ab;
	wire        ge_signed;
	wire        ge_unsigned;
	wire        lt_signed;
	wire        is_and;
	wire        known_op;
	wire        take_br;
	wire        trap_d;
	wire [4:0]  idx_a;
	wire [4:0]  idx_b;
	genvar      k;

	// taken branch whose target is off a word boundary; and ops never get here
	function misalign_cond;
		input        br;
		input        c;
		input [31:0] t;
		begin
			misalign_cond = br & c & (t[1:0] != 2'b00);
		end
	endfunction

	// field split of the instruction word
	assign opc                   = instr_word[`AICB_OPC_HI:`AICB_OPC_LO];
	assign sixteen_bit_immediate = instr_word[`AICB_IMM_HI:`AICB_IMM_LO];
	assign is_andhi              = (opc == `AICB_OP_ANDHI);
	assign is_andlo              = (opc == `AICB_OP_ANDLO);
	assign is_beq                = (opc == `AICB_OP_BEQ);
	assign is_bge                = (opc == `AICB_OP_BGE);
	assign is_bgeu               = (opc == `AICB_OP_BGEU);
	assign is_blt                = (opc == `AICB_OP_BLT);
	assign is_branch             = is_beq | is_bge | is_bgeu | is_blt;
	assign is_and                = is_andhi | is_andlo;
	assign known_op              = is_branch | is_and;
	assign idx_a                 = instr_word[`AICB_A_HI:`AICB_A_LO];
	assign idx_b                 = instr_word[`AICB_B_HI:`AICB_B_LO];

	// immediate masks built bit by bit; the half not covered stays zero
	generate
		for (k = 0; k < 32; k = k + 1) begin : g_mask
			if (k >= 16) begin : g_hi
				assign hi_mask[k] = sixteen_bit_immediate[k-16];
				assign lo_mask[k] = 1'b0;
			end else begin : g_lo
				assign hi_mask[k] = 1'b0;
				assign lo_mask[k] = sixteen_bit_immediate[k];
			end
		end
	endgenerate

	// both and results are formed every cycle; the opcode picks one
	assign hi_res = first_source_val & hi_mask;
	assign lo_res = first_source_val & lo_mask;

	// all four compares run in parallel; cheaper to route than a shared mux
	assign eq_ab       = (first_source_val == second_source_val);
	assign ge_signed   = ($signed(first_source_val) >= $signed(second_source_val));
	assign ge_unsigned = (first_source_val >= second_source_val);
	assign lt_signed   = ~ge_signed;

	// displacement counts from the following instruction
	assign imm_sext = {{16{sixteen_bit_immediate[15]}}, sixteen_bit_immediate};
	assign seq_pc   = instr_pc + `AICB_PC_STEP;
	assign tgt_pc   = seq_pc + imm_sext;

	// branch condition; aliases arrive already swapped, so no extra compares
	always @* begin
		cond = 1'b0;
		case (opc)
			`AICB_OP_BEQ: begin
				cond = eq_ab;
			end
			`AICB_OP_BGE: begin
				cond = ge_signed;
			end
			`AICB_OP_BGEU: begin
				cond = ge_unsigned;
			end
			`AICB_OP_BLT: begin
				cond = lt_signed;
			end
			default:       cond = 1'b0;
		endcase
	end

	// register-file read indices, registered so the port comes from a flop
	always @(posedge core_clk) begin
		if (sys_rst) begin
			first_source_reg <= 5'h00;
			second_reg_field <= 5'h00;
		end else begin
			first_source_reg <= instr_word[`AICB_A_HI:`AICB_A_LO];
			second_reg_field <= instr_word[`AICB_B_HI:`AICB_B_LO];
		end
	end

	// outcome of a valid branch; trap_d feeds the pc and flag processes, take_br only the flags
	assign take_br = instr_valid & is_branch & cond;
	assign trap_d  = instr_valid & misalign_cond(is_branch, cond, tgt_pc);

	// write-back port: enable pulses only for the two and forms
	always @(posedge core_clk) begin
		if (sys_rst) begin
			wr_en_q  <= 1'b0;
			wr_idx_q <= `AICB_RST_IDX;
		end else begin
			wr_en_q  <= instr_valid & is_and;
			wr_idx_q <= idx_b;
		end
	end

	// result word; follows the instruction every cycle, qualified by wr_en_q
	always @(posedge core_clk) begin
		if (sys_rst) begin
			wr_data_q <= `AICB_RST_DATA;
		end else begin
			if (is_andhi) begin
				wr_data_q <= hi_res;
			end else begin
				wr_data_q <= lo_res;
			end
		end
	end

	// next program counter; a trapped target is still shown for the handler
	always @(posedge core_clk) begin
		if (sys_rst) begin
			pc_valid_q <= 1'b0;
			next_pc_q  <= `AICB_RST_PC;
		end else begin
			pc_valid_q <= instr_valid & ~trap_d;
			if (is_branch & cond) begin
				next_pc_q <= tgt_pc;
			end else begin
				next_pc_q <= seq_pc;
			end
		end
	end

	// status pulses, each one cycle after the instruction edge
	always @(posedge core_clk) begin
		if (sys_rst) begin
			branch_taken_q <= 1'b0;
			misalign_exc_q <= 1'b0;
			illegal_q      <= 1'b0;
		end else begin
			branch_taken_q <= take_br;
			misalign_exc_q <= trap_d;
			illegal_q      <= instr_valid & ~known_op; // unknown opcode: pc still steps
		end
	end
endmodule // aicb_exec

// *** design/aicb_defs.vh ***
// constants for the and-immediate and compare-branch execute block
`ifndef AICB_DEFS_VH
`define AICB_DEFS_VH
`define AICB_OP_ANDHI    6'h2C
`define AICB_OP_ANDLO    6'h0C
`define AICB_OP_BEQ      6'h26
`define AICB_OP_BGE      6'h0E
`define AICB_OP_BGEU     6'h2E
`define AICB_OP_BLT      6'h16
`define AICB_A_HI        31
`define AICB_A_LO        27
`define AICB_B_HI        26
`define AICB_B_LO        22
`define AICB_IMM_HI      21
`define AICB_IMM_LO      6
`define AICB_OPC_HI      5
`define AICB_OPC_LO      0
`define AICB_PC_STEP     32'h00000004
`define AICB_ZERO16      16'h0000
`define AICB_RST_PC      32'h00000000
`define AICB_RST_IDX     5'h00
`define AICB_RST_DATA    32'h00000000
`endif

// *** verification/aicb_exec_checker.sv ***
// port assertions for the and-immediate and branch execute block
module aicb_chk (
	input logic        core_clk, sys_rst, instr_valid, wr_en_q, pc_valid_q, branch_taken_q, misalign_exc_q,
	input logic [31:0] instr_word, instr_pc, first_source_val, second_source_val, wr_data_q, next_pc_q,
	input logic [4:0]  wr_idx_q
);
	// short aliases keep each property on one line
	wire [31:0] a = first_source_val;
	wire [31:0] b = second_source_val;
	wire [15:0] m = instr_word[21:6];
	wire [5:0]  o = instr_word[5:0];
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	andhi_res_a: assert property (instr_valid&&o==6'h2C |=> wr_en_q&&wr_data_q==($past(a)&{$past(m),16'h0000}))
		else $error("andhi result wrong");
	andlo_res_a: assert property (instr_valid&&o==6'h0C |=> wr_en_q&&wr_data_q==($past(a)&{16'h0000,$past(m)}))
		else $error("andi result wrong");
	wr_dest_a: assert property (wr_en_q |-> wr_idx_q==$past(instr_word[26:22])) else $error("dest wrong");
	beq_take_a: assert property (instr_valid&&o==6'h26 |=> branch_taken_q==($past(a)==$past(b)))
		else $error("beq wrong");
	bge_take_a: assert property (instr_valid&&o==6'h0E |=> branch_taken_q==($signed($past(a))>=$signed($past(b))))
		else $error("bge wrong");
	bgeu_take_a: assert property (instr_valid&&o==6'h2E |=> branch_taken_q==($past(a)>=$past(b)))
		else $error("bgeu wrong");
	blt_take_a: assert property (instr_valid&&o==6'h16 |=> branch_taken_q==($signed($past(a))<$signed($past(b))))
		else $error("blt wrong");
	br_target_a: assert property (branch_taken_q |-> next_pc_q==$past(instr_pc)+32'h00000004+{{16{$past(m[15])}},$past(m)})
		else $error("target wrong");
	// an unaligned target must suppress the pc update
	misalign_a: assert property (branch_taken_q |-> misalign_exc_q==(next_pc_q[1:0]!=2'h0)&&pc_valid_q==!misalign_exc_q)
		else $error("misalign wrong");
endmodule // aicb_chk
bind aicb_exec aicb_chk aicb_chk_inst (.core_clk, .sys_rst, .instr_valid, .wr_en_q, .pc_valid_q, .branch_taken_q,
	.misalign_exc_q, .instr_word, .instr_pc, .first_source_val, .second_source_val, .wr_data_q, .next_pc_q, .wr_idx_q);

// *** verification/tb_aicb_exec.sv ***
// self-checking bench for the and-immediate and branch execute block
module tb_aicb_exec;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk = 0, sys_rst = 1, iv = 0;
	logic [31:0] iw = 0, pc = 0, va = 0, vb = 0;
	wire  [4:0]  ra_o, rb_o, wi;
	wire         we, pv, bt, me, il;
	wire  [31:0] wd, np;
	int          error_cnt = 0, n_tests = 0;
	logic [5:0]  ops [4] = '{6'h26, 6'h0E, 6'h2E, 6'h16};
	localparam logic [3:0] TK_LT = 4'b1100, TK_EQ = 4'b0111;
	aicb_exec aicb_exec_inst (.core_clk, .sys_rst, .instr_valid(iv), .instr_word(iw), .instr_pc(pc),
		.first_source_val(va), .second_source_val(vb), .first_source_reg(ra_o), .second_reg_field(rb_o),
		.wr_en_q(we), .wr_idx_q(wi), .wr_data_q(wd), .pc_valid_q(pv), .next_pc_q(np), .branch_taken_q(bt),
		.misalign_exc_q(me), .illegal_q(il));
	initial forever #2.5 core_clk = ~core_clk;
	task chk(input logic [63:0] s, e);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %0t seen %h exp %h", $time, s, e);
		end
	endtask
	// one instruction in, results settle one edge later
	task ex(input logic [31:0] w, p, a, b);
		@(posedge core_clk);
		{iv, iw, pc, va, vb} <= {1'b1, w, p, a, b};
		@(posedge core_clk);
		iv <= 1'b0;
		#1;
	endtask
	task t_and;
		ex({5'h03, 5'h1D, 16'hA5C3, 6'h2C}, 0, 32'hFFFFFFFF, 0);
		chk(wd, 32'hA5C30000);
		chk({we, me, wi, ra_o, rb_o}, {2'h2, 5'h1D, 5'h03, 5'h1D});
		ex({5'h03, 5'h1D, 16'hA5C3, 6'h0C}, 0, 32'hFFFFFFFF, 0);
		chk(wd, 32'h0000A5C3);
		chk({we, pv, bt, np}, {3'b110, 32'h00000004});
		$display("and test done");
	endtask
	// signed and unsigned views disagree on ffffffff against 1
	task t_br;
		for (int i = 0; i < 4; i++) begin
			ex({5'h03, 5'h1D, 16'hFFF8, ops[i]}, 32'h100, 32'hFFFFFFFF, 32'h1);
			chk({bt, np}, {TK_LT[i], TK_LT[i] ? 32'h000000FC : 32'h00000104});
			ex({5'h03, 5'h1D, 16'hFFF8, ops[i]}, 32'h100, 32'h5, 32'h5);
			chk({bt, pv, np}, {TK_EQ[i], 1'b1, TK_EQ[i] ? 32'h000000FC : 32'h00000104});
		end
		ex({5'h03, 5'h1D, 16'h0006, 6'h26}, 32'h100, 32'h7, 32'h7);
		chk({bt, me, pv, np}, {3'h6, 32'h0000010A});
		$display("branch test done");
	endtask
	// aliases arrive as real compares with swapped operands; unknown opcode only flags
	task t_alias;
		ex({5'h1D, 5'h03, 16'h0010, 6'h16}, 32'h200, 32'h2, 32'h5);
		chk({bt, np}, {1'b1, 32'h00000214});
		ex({5'h1D, 5'h03, 16'h0010, 6'h2E}, 32'h200, 32'h3, 32'h7);
		chk({bt, np}, {1'b0, 32'h00000204});
		ex({5'h03, 5'h1D, 16'h0010, 6'h36}, 32'h300, 32'h1, 32'h1);
		chk({il, pv, bt, we, me, np}, {5'h18, 32'h00000304});
		$display("alias test done");
	endtask
	task test_done;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge core_clk);
		sys_rst <= 1'b0;
		#1 chk({we, pv, bt, me, il, np}, 0);
		t_and;
		t_br;
		t_alias;
		test_done;
	end
endmodule // tb_aicb_exec
